// ===== hdl/imdr_pkg.sv
/*
  Constants, types and the register map of the two-wire master data block.
  Assumes an 8-bit special-function register port on the system clock.
*/
package imdr_pkg;
  // Register addresses in the special-function space.
  localparam logic [15:0] ADDR_SAD = 16'hff80;
  localparam logic [15:0] ADDR_WR1 = 16'hff81;
  localparam logic [15:0] ADDR_WR2 = 16'hff82;
  localparam logic [15:0] ADDR_RD1 = 16'hff83;
  localparam logic [15:0] ADDR_RD2 = 16'hff84;
  localparam logic [15:0] ADDR_CTL = 16'hff85;
  // Field positions.
  localparam int DIR_BIT = 0;
  localparam int LEN_BIT = 0;
  localparam int START_BIT = 1;
  localparam int ACKERR_BIT = 2;
  // Values after reset.
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Timing: one bus bit at 400 kHz, split into four quarter phases.
  localparam int CLK_NS = 5;
  localparam int BIT_NS = 2500;
  localparam int QTR_CYC = BIT_NS / (4 * CLK_NS);
  localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);
  localparam logic [3:0] ACK_SLOT = 4'h8;
  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } imdr_sfr_t;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS, ST_STOP} imdr_state_t;
endpackage

// ===== hdl/imdr_top.sv
/*
  Two-wire master with its address, write-data and read-data registers.
  Assumes the processor writes registers through one strobe per cycle, that
  the bus lines are open drain with external pull-ups, and that the
  completion enable arrives from logic on the same clock.
*/
// Functional notes
// - Address register holds seven-bit slave address
// - Address bit zero selects write or read
// - First write register is first data byte
// - Second write byte sent only when length set
// - First received byte lands in first read register
// - Second received byte captured only when length set
// - Length bit selects one or two bytes
// - Start bit launches, stays busy until done
// - Missing acknowledge sets error, cleared on start
// - Completion flag cleared on start; interrupt gated by enable
`timescale 1ns/1ps
module imdr_top
  import imdr_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire imdr_sfr_t SFR,
  output logic [7:0] SFR_RDATA,
  input wire logic DONE_ENABLE,
  output logic DONE_FLAG,
  output logic DONE_IRQ,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE
);
  imdr_state_t state_q;
  logic [7:0] sad_q, wr1_q, wr2_q, rd1_q, rd2_q, shift_q, rdata_q;
  logic len_q, busy_q, ack_err_q, done_q, irq_q;
  logic [6:0] div_q;
  logic [1:0] ph_q, byte_idx_q, last_idx;
  logic [3:0] bit_cnt_q;
  logic sda_m_q, sda_s_q, rx_bit_q, scl_low_q, sda_low_q;
  logic scl_low_d, sda_low_d;
  logic tick, ph_end, go, reg_wr, csr_wr, rx_byte, byte_end;
  logic [7:0] next_byte;

  assign csr_wr = SFR.wr && (SFR.addr == ADDR_CTL);
  assign go = csr_wr && SFR.wdata[START_BIT] && !busy_q;
  // Data registers are frozen while a transfer runs.
  assign reg_wr = SFR.wr && !busy_q;
  assign tick = busy_q && (div_q == QTR_LAST);
  assign ph_end = tick && (ph_q == 2'd3);
  assign last_idx = len_q ? 2'd2 : 2'd1;
  assign rx_byte = sad_q[DIR_BIT] && (byte_idx_q != 2'd0);
  assign byte_end = (state_q == ST_BITS) && ph_end
                    && (bit_cnt_q == ACK_SLOT);

  always_comb begin
    if (sad_q[DIR_BIT]) begin
      next_byte = 8'hff;
    end else if (byte_idx_q == 2'd0) begin
      next_byte = wr1_q;
    end else begin
      next_byte = wr2_q;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      sda_m_q <= SDA_I;
      sda_s_q <= sda_m_q;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_q <= 7'h00;
      ph_q <= 2'h0;
    end else if (!busy_q || go) begin
      div_q <= 7'h00;
      ph_q <= 2'h0;
    end else if (tick) begin
      div_q <= 7'h00;
      ph_q <= ph_q + 2'd1;
    end else begin
      div_q <= div_q + 7'd1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sad_q <= RST_BYTE;
      wr1_q <= RST_BYTE;
      wr2_q <= RST_BYTE;
      len_q <= 1'b0;
    end else if (reg_wr) begin
      case (SFR.addr)
        ADDR_SAD: sad_q <= SFR.wdata;
        ADDR_WR1: wr1_q <= SFR.wdata;
        ADDR_WR2: wr2_q <= SFR.wdata;
        ADDR_CTL: len_q <= SFR.wdata[LEN_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (go) state_q <= ST_START;
        ST_START: if (ph_end) state_q <= ST_BITS;
        ST_BITS: if (byte_end && byte_idx_q == last_idx) state_q <= ST_STOP;
        ST_STOP: if (ph_end) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      byte_idx_q <= 2'h0;
      bit_cnt_q <= 4'h0;
      shift_q <= RST_BYTE;
    end else if (go) begin
      byte_idx_q <= 2'h0;
      bit_cnt_q <= 4'h0;
      shift_q <= sad_q;
    end else if (byte_end) begin
      bit_cnt_q <= 4'h0;
      byte_idx_q <= byte_idx_q + 2'd1;
      shift_q <= next_byte;
    end else if (state_q == ST_BITS && ph_end) begin
      bit_cnt_q <= bit_cnt_q + 4'd1;
      shift_q <= {shift_q[6:0], rx_bit_q};
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_bit_q <= 1'b1;
    end else if (state_q == ST_BITS && tick && ph_q == 2'd2) begin
      rx_bit_q <= sda_s_q;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd1_q <= RST_BYTE;
      rd2_q <= RST_BYTE;
    end else if (byte_end && rx_byte) begin
      if (byte_idx_q == 2'd1) begin
        rd1_q <= shift_q;
      end else begin
        rd2_q <= shift_q;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (go) begin
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end else if (state_q == ST_STOP && ph_end) begin
      busy_q <= 1'b0;
      done_q <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_err_q <= 1'b0;
    end else if (go) begin
      ack_err_q <= 1'b0;
    end else if (state_q == ST_BITS && tick && ph_q == 2'd2
                 && bit_cnt_q == ACK_SLOT && !rx_byte && sda_s_q) begin
      ack_err_q <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= done_q && DONE_ENABLE;
    end
  end

  // Quarter phases of a data bit: 0 and 3 hold the clock low, 1 and 2 release it.
  always_comb begin
    scl_low_d = 1'b0;
    sda_low_d = 1'b0;
    case (state_q)
      ST_START: begin
        scl_low_d = (ph_q == 2'd3);
        sda_low_d = (ph_q != 2'd0);
      end
      ST_BITS: begin
        scl_low_d = (ph_q == 2'd0) || (ph_q == 2'd3);
        if (bit_cnt_q != ACK_SLOT) begin
          sda_low_d = !rx_byte && !shift_q[7];
        end else begin
          sda_low_d = rx_byte && (byte_idx_q != last_idx);
        end
      end
      ST_STOP: begin
        scl_low_d = (ph_q == 2'd0);
        sda_low_d = (ph_q == 2'd0) || (ph_q == 2'd1);
      end
      default: ;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= RST_BYTE;
    end else begin
      case (SFR.addr)
        ADDR_SAD: rdata_q <= sad_q;
        ADDR_WR1: rdata_q <= wr1_q;
        ADDR_WR2: rdata_q <= wr2_q;
        ADDR_RD1: rdata_q <= rd1_q;
        ADDR_RD2: rdata_q <= rd2_q;
        ADDR_CTL: rdata_q <= {5'h00, ack_err_q, busy_q, len_q};
        default: rdata_q <= RST_BYTE;
      endcase
    end
  end

  assign SFR_RDATA = rdata_q;
  assign DONE_FLAG = done_q;
  assign DONE_IRQ = irq_q;
  assign SCL_O = 1'b0;
  assign SCL_OE = scl_low_q;
  assign SDA_O = 1'b0;
  assign SDA_OE = sda_low_q;

  sequence s_go;
    csr_wr && SFR.wdata[START_BIT] && !busy_q;
  endsequence
  sequence s_nack;
    state_q == ST_BITS && tick && ph_q == 2'd2 && bit_cnt_q == ACK_SLOT
      && !rx_byte && sda_s_q;
  endsequence

  property p_go_clears;
    @(posedge SYS_CLK) disable iff (!RST_N)
    s_go |=> busy_q && !ack_err_q && !done_q && state_q == ST_START;
  endproperty
  a_go_clears: assert property (p_go_clears)
    else $error("start did not set busy and clear flags");
  property p_done_at_end;
    @(posedge SYS_CLK) disable iff (!RST_N)
    $fell(busy_q) |-> done_q && state_q == ST_IDLE;
  endproperty
  a_done_at_end: assert property (p_done_at_end)
    else $error("busy fell without completion flag");
  property p_irq_gate;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (done_q && !DONE_ENABLE) |=> !DONE_IRQ;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised while disabled");
  property p_nack_err;
    @(posedge SYS_CLK) disable iff (!RST_N)
    s_nack |=> ack_err_q;
  endproperty
  a_nack_err: assert property (p_nack_err)
    else $error("missing acknowledge not flagged");
  property p_frozen;
    @(posedge SYS_CLK) disable iff (!RST_N)
    busy_q |=> $stable(wr1_q) && $stable(wr2_q) && $stable(sad_q);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("register changed during transfer");
  property p_addr_load;
    @(posedge SYS_CLK) disable iff (!RST_N)
    s_go |=> shift_q == $past(sad_q);
  endproperty
  a_addr_load: assert property (p_addr_load)
    else $error("address byte not loaded at start");
  property p_first_data;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (byte_end && byte_idx_q == 2'd0 && !sad_q[DIR_BIT]) |=> shift_q == wr1_q;
  endproperty
  a_first_data: assert property (p_first_data)
    else $error("first write byte not loaded");
  property p_one_byte;
    @(posedge SYS_CLK) disable iff (!RST_N)
    !(state_q == ST_BITS && !len_q && byte_idx_q == 2'd2);
  endproperty
  a_one_byte: assert property (p_one_byte)
    else $error("second byte moved in one-byte mode");
  property p_rd1_cap;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (byte_end && rx_byte && byte_idx_q == 2'd1) |=> rd1_q == $past(shift_q);
  endproperty
  a_rd1_cap: assert property (p_rd1_cap)
    else $error("first read byte not captured");
  property p_rd2_hold;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (busy_q && !len_q) |=> $stable(rd2_q);
  endproperty
  a_rd2_hold: assert property (p_rd2_hold)
    else $error("second read register changed in one-byte mode");
  property p_start_cond;
    @(posedge SYS_CLK) disable iff (!RST_N)
    ($rose(SDA_OE) && !SCL_OE) |-> $past(state_q) == ST_START;
  endproperty
  a_start_cond: assert property (p_start_cond)
    else $error("data fell with clock high outside start");
endmodule

// ===== verification/imdr_slave.sv
/*
  Behavioural two-wire slave that records what it receives and sends bytes.
  Assumes the bench resolves both open-drain lines with pull-ups.
*/
`timescale 1ns/1ps
module imdr_slave (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack_en,
  input wire logic [15:0] tx,
  output logic pull,
  output logic [23:0] rx,
  output logic [1:0] macks,
  output int cnt
);
  logic [7:0] sh;
  logic [15:0] d;
  logic stop;
  initial begin
    pull = 0;
    rx = 0;
    cnt = 0;
    macks = 0;
    forever begin
      @(negedge sda iff scl === 1'b1);
      cnt = 0;
      stop = 0;
      while (!stop) begin
        @(posedge scl);
        sh[0] = sda;
        @(negedge scl or posedge sda);
        if (scl) stop = 1;
        else begin
          repeat (7) begin
            @(posedge scl);
            sh = {sh[6:0], sda};
            @(negedge scl);
          end
          rx = {rx[15:0], sh};
          cnt++;
          pull = !nack_en;
          @(negedge scl);
          pull = 0;
          if (cnt == 1 && sh[0]) begin
            d = tx;
            for (int j = 0; j < 16; j++) begin
              pull = !d[15];
              d = d << 1;
              @(negedge scl);
              if (j % 8 == 7) begin
                pull = 0;
                @(posedge scl);
                macks = {macks[0], sda};
                @(negedge scl);
                if (macks[0]) j = 16;
              end
            end
            pull = 0;
          end
        end
      end
    end
  end
endmodule

// ===== verification/tb.sv
/*
  Bench for the two-wire master data block: register tasks and transfers.
  Assumes the slave model and open-drain lines with pull-ups.
*/
`timescale 1ns/1ps
module tb;
  import imdr_pkg::*;
  logic sys_clk = 0;
  logic rst_n = 0;
  imdr_sfr_t sfr = '0;
  logic [7:0] rdata;
  logic done_en = 0;
  logic nack_en = 0;
  logic done_flag, done_irq, scl_oe, sda_oe, pull, scl_o, sda_o;
  logic [15:0] tx = 16'h0000;
  logic [23:0] rx;
  logic [1:0] macks;
  int cnt;
  int err_total = 0;
  int checks = 0;
  wire scl = !scl_oe;
  wire sda = !(sda_oe || pull);
  always #2.5 sys_clk = !sys_clk;
  imdr_top DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .SFR(sfr),
    .SFR_RDATA(rdata), .DONE_ENABLE(done_en), .DONE_FLAG(done_flag),
    .DONE_IRQ(done_irq), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe));
  imdr_slave slave (.scl(scl), .sda(sda), .nack_en(nack_en), .tx(tx),
    .pull(pull), .rx(rx), .macks(macks), .cnt(cnt));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
    input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr = '{1'b1, a, d};
    @(negedge sys_clk);
    sfr.wr = 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    sfr.addr = a;
    @(negedge sys_clk);
    chk(rdata, e, "read");
  endtask
  task automatic run(input logic [7:0] sad, input logic [7:0] ctl);
    int n;
    n = 0;
    wr(ADDR_SAD, sad);
    wr(ADDR_CTL, ctl);
    chk(done_flag, 0, "flag");
    rd(ADDR_CTL, ctl & 8'h03);
    wr(ADDR_SAD, 8'h00);
    rd(ADDR_SAD, sad);
    while (done_flag !== 1'b1 && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n < 20000, 1, "done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    stop_test();
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    rst_n = 1;
    for (int a = 16'hff80; a <= 16'hff86; a++) rd(16'(a), 8'h00);
    wr(ADDR_RD1, 8'h77);
    rd(ADDR_RD1, 8'h00);
    chk({scl_o, sda_o, scl_oe, sda_oe}, 24'h0, "idle lines");
    $display("test reset done");
    done_en = 1;
    wr(ADDR_WR1, 8'h3c);
    wr(ADDR_WR2, 8'h99);
    rd(ADDR_WR2, 8'h99);
    run(8'ha4, 8'h02);
    chk(rx[15:0], 16'ha43c, "wr1");
    chk(cnt, 2, "len1");
    rd(ADDR_CTL, 8'h00);
    chk(done_irq, 1, "irq");
    $display("test write one done");
    nack_en = 1;
    done_en = 0;
    run(8'ha4, 8'h03);
    chk(rx, 24'ha43c99, "wr2");
    rd(ADDR_CTL, 8'h05);
    chk(done_irq, 0, "masked");
    $display("test write two done");
    nack_en = 0;
    tx = 16'h5ac3;
    run(8'ha5, 8'h03);
    chk(rx[7:0], 8'ha5, "rdaddr");
    rd(ADDR_CTL, 8'h01);
    rd(ADDR_RD1, 8'h5a);
    rd(ADDR_RD2, 8'hc3);
    chk(macks, 2'b01, "acks");
    $display("test read two done");
    tx = 16'h8100;
    run(8'ha5, 8'h02);
    rd(ADDR_RD1, 8'h81);
    rd(ADDR_RD2, 8'hc3);
    chk(macks, 2'b11, "nack");
    chk({scl_o, sda_o}, 24'h0, "drive level");
    $display("test read one done");
    stop_test();
  end
endmodule
